// ### logic/acsp_pkg.sv
// shared constants and types for the serial configuration port
package acsp_pkg;
  // device register map
  localparam logic [7:0] ADDR_PORT_CFG = 8'h00;
  localparam logic [7:0] ADDR_CHIP_ID = 8'h01;
  localparam logic [7:0] ADDR_CHIP_GRADE = 8'h02;
  localparam logic [7:0] ADDR_DEV_INDEX = 8'h05;
  localparam logic [7:0] ADDR_CLOCK_SETTINGS = 8'h09;
  localparam logic [7:0] ADDR_REGISTER_UPDATE = 8'hFF;
  localparam logic [7:0] RST_PORT_CFG = 8'h18;
  localparam logic [3:0] RST_DEV_INDEX = 4'hF;
  localparam logic [7:0] RST_CLOCK_SETTINGS = 8'h01;
  localparam int CFG_SEP_OUT_BIT = 7;
  localparam int CFG_LSB_FIRST_BIT = 6;
  localparam int CFG_SOFT_RESET_BIT = 5;
  localparam int UPDATE_BIT = 0;
  localparam int DCS_BIT = 0;
  // instruction word
  localparam int INSTR_BITS = 16;
  localparam int INSTR_RW_BIT = 15;
  localparam logic [1:0] LEN_STREAM = 2'h3;
  // timing
  localparam int SYS_CLK_NS = 100;
  localparam int SCLK_MIN_PERIOD_NS = 40;
  localparam int SCLK_PERIOD_NS = 1600;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * SYS_CLK_NS);
  localparam int STALL_NS = 3200;
  localparam int STALL_CYC = STALL_NS / SYS_CLK_NS;
  localparam int SECONDARY_NS = 6400;
  localparam int SECONDARY_CYC = SECONDARY_NS / SYS_CLK_NS;
  // bench-made link clock for the bit-banged port
  localparam int BENCH_SCLK_NS = 800;
  localparam int BENCH_HALF_CYC = BENCH_SCLK_NS / (2 * SYS_CLK_NS);
  // host command port
  localparam logic [3:0] HOST_ADDR_INSTR = 4'h0;
  localparam logic [3:0] HOST_ADDR_TXDATA = 4'h1;
  localparam logic [3:0] HOST_ADDR_CTRL = 4'h2;
  localparam logic [3:0] HOST_ADDR_STATUS = 4'h3;
  localparam logic [3:0] HOST_ADDR_RXDATA = 4'h4;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_LSB_BIT = 1;
  localparam int CTRL_SDO_BIT = 2;
  localparam int CTRL_STALL_BIT = 3;
  typedef enum logic {ST_INSTR, ST_DATA} acsp_dev_state_t;
  typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_STALL, H_END} acsp_host_state_t;
endpackage

// ### logic/acsp_if.sv
// serial link between the controller and the configuration port
interface acsp_if;
  logic sclk;
  logic csN;
  logic sdioHostOut;
  logic sdioHostOe;
  logic sdioDevOut;
  logic sdioDevOe;
  logic sdoOut;
  logic sdoOe;
  logic sdioLine;
  logic sdoLine;
  // board pull-downs hold undriven lines low
  assign sdioLine = sdioDevOe ? sdioDevOut : (sdioHostOe ? sdioHostOut : 1'b0);
  assign sdoLine = sdoOe ? sdoOut : 1'b0;
  modport dev (input sclk, input csN, input sdioLine,
    output sdioDevOut, output sdioDevOe, output sdoOut, output sdoOe);
  modport host (output sclk, output csN, output sdioHostOut, output sdioHostOe,
    input sdioLine, input sdoLine);
endinterface

// ### logic/acsp_device.sv
// device end: serial configuration port with staged register map
// Function
// - frame starts at select low, clock rise
// - sixteen-bit instruction, then length-coded data bytes
// - shift only while select low
// - select high between bytes stalls transfer
// - length 11 streams until select rises
// - select high mid-byte resets to instruction
// - select held high gives secondary pin mode
// - select tied low: two-wire, stream never ends
// - two-wire host keeps short transfers, alignment
// - instruction picks write or readback
// - readback drives data pin after instruction
// - separate output enable picks output pin
// - MSB first by default, LSB selectable
// - input bits captured on clock rise
// - clock period 40 ns, phases 16 ns
// - pin turns out on fall, in on rise; a stream read lets go only when select rises
// - byte registers in three address groups
// - writes other than port config staged until update register written
// - clock register resets 0x01, bit0 stabiliser
// - reset restores every register default
module acsp_device #(
  parameter logic [7:0] CHIP_ID_VALUE = 8'h5A, // arbitrary value
  parameter logic [7:0] CHIP_GRADE_VALUE = 8'h00 // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  acsp_if.dev link,
  output logic dcsEnable,
  output logic [3:0] deviceIndex,
  output logic secondaryMode
);
  import acsp_pkg::*;

  logic [2:0] sclkSync_ff;
  logic [1:0] csSync_ff;
  logic [1:0] sdioSync_ff;
  logic sclkRise;
  logic sclkFall;
  logic csHigh;
  logic sdioIn;
  logic [7:0] portCfg_ff;
  logic [3:0] idxShadow_ff;
  logic [3:0] idxActive_ff;
  logic [7:0] clkShadow_ff;
  logic [7:0] clkActive_ff;
  logic lsbFirst;
  logic sepOut;
  acsp_dev_state_t state_ff;
  logic [3:0] bitCnt_ff;
  logic [15:0] instrSh_ff;
  logic [7:0] rxSh_ff;
  logic [7:0] txSh_ff;
  logic isRead_ff;
  logic [1:0] lenCode_ff;
  logic [1:0] bytesLeft_ff;
  logic [12:0] addr_ff;
  logic [15:0] nxt_instr;
  logic [7:0] nxt_rx;
  logic [12:0] nxt_addr;
  logic byteDone;
  logic lastByte;
  logic wrStrobe;
  logic outBit_ff;
  logic sdioOe_ff;
  logic sdoOe_ff;
  logic [6:0] csHighCnt_ff;
  logic secondary_ff;

  // link pins are asynchronous to sys_clk
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclkSync_ff <= 3'h0;
      csSync_ff <= 2'h3;
      sdioSync_ff <= 2'h0;
    end else begin
      sclkSync_ff <= {sclkSync_ff[1:0], link.sclk};
      csSync_ff <= {csSync_ff[0], link.csN};
      sdioSync_ff <= {sdioSync_ff[0], link.sdioLine};
    end
  end

  assign sclkRise = sclkSync_ff[1] & ~sclkSync_ff[2];
  assign sclkFall = ~sclkSync_ff[1] & sclkSync_ff[2];
  assign csHigh = csSync_ff[1];
  assign sdioIn = sdioSync_ff[1];
  assign lsbFirst = portCfg_ff[CFG_LSB_FIRST_BIT];
  assign sepOut = portCfg_ff[CFG_SEP_OUT_BIT];

  assign nxt_instr = lsbFirst ? {sdioIn, instrSh_ff[15:1]} : {instrSh_ff[14:0], sdioIn};
  assign nxt_rx = lsbFirst ? {sdioIn, rxSh_ff[7:1]} : {rxSh_ff[6:0], sdioIn};
  assign nxt_addr = lsbFirst ? addr_ff + 13'h0001 : addr_ff - 13'h0001;
  assign byteDone = sclkRise && !csHigh && state_ff == ST_DATA && bitCnt_ff == 4'h7;
  assign lastByte = lenCode_ff != LEN_STREAM && bytesLeft_ff == 2'h0;
  assign wrStrobe = byteDone && !isRead_ff;

  // readback view; unimplemented converter addresses read zero
  function automatic logic [7:0] rdReg(input logic [12:0] a);
    rdReg = 8'h00;
    if (a[12:8] == 5'h00) begin
      case (a[7:0])
        ADDR_PORT_CFG: rdReg = portCfg_ff;
        ADDR_CHIP_ID: rdReg = CHIP_ID_VALUE;
        ADDR_CHIP_GRADE: rdReg = CHIP_GRADE_VALUE;
        ADDR_DEV_INDEX: rdReg = {4'h0, idxShadow_ff};
        ADDR_CLOCK_SETTINGS: rdReg = clkShadow_ff;
        default: rdReg = 8'h00;
      endcase
    end
  endfunction

  // serial frame sequencing
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_INSTR;
      bitCnt_ff <= 4'h0;
      instrSh_ff <= 16'h0000;
      rxSh_ff <= 8'h00;
      txSh_ff <= 8'h00;
      isRead_ff <= 1'b0;
      lenCode_ff <= 2'h0;
      bytesLeft_ff <= 2'h0;
      addr_ff <= 13'h0000;
    end else if (csHigh) begin
      // stall keeps position at byte boundaries; a stream has none
      if (bitCnt_ff[2:0] != 3'h0) begin
        state_ff <= ST_INSTR;
        bitCnt_ff <= 4'h0;
      end else if (state_ff == ST_DATA && lenCode_ff == LEN_STREAM) begin
        state_ff <= ST_INSTR;
      end
    end else if (sclkRise) begin
      unique case (state_ff)
        ST_INSTR: begin
          instrSh_ff <= nxt_instr;
          bitCnt_ff <= bitCnt_ff + 4'h1;
          if (bitCnt_ff == 4'(INSTR_BITS - 1)) begin
            state_ff <= ST_DATA;
            bitCnt_ff <= 4'h0;
            isRead_ff <= nxt_instr[INSTR_RW_BIT];
            lenCode_ff <= nxt_instr[14:13];
            bytesLeft_ff <= nxt_instr[14:13];
            addr_ff <= nxt_instr[12:0];
            txSh_ff <= rdReg(nxt_instr[12:0]);
          end
        end
        ST_DATA: begin
          rxSh_ff <= nxt_rx;
          if (bitCnt_ff == 4'h7) begin
            bitCnt_ff <= 4'h0;
            addr_ff <= nxt_addr;
            txSh_ff <= rdReg(nxt_addr);
            // with select tied low a stream never sees an end
            if (lastByte) begin
              state_ff <= ST_INSTR;
            end else if (lenCode_ff != LEN_STREAM) begin
              bytesLeft_ff <= bytesLeft_ff - 2'h1;
            end
          end else begin
            bitCnt_ff <= bitCnt_ff + 4'h1;
          end
        end
      endcase
    end else if (sclkFall && state_ff == ST_DATA && isRead_ff) begin
      txSh_ff <= lsbFirst ? {1'b0, txSh_ff[7:1]} : {txSh_ff[6:0], 1'b0};
    end
  end

  // read data driver; enable follows the falling edge, release the last byte's rising one or select high
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      outBit_ff <= 1'b0;
      sdioOe_ff <= 1'b0;
      sdoOe_ff <= 1'b0;
    end else if (csHigh) begin
      sdioOe_ff <= 1'b0;
      sdoOe_ff <= 1'b0;
    end else if (sclkFall && state_ff == ST_DATA && isRead_ff) begin
      outBit_ff <= lsbFirst ? txSh_ff[0] : txSh_ff[7];
      sdioOe_ff <= !sepOut;
      sdoOe_ff <= sepOut;
    end else if (byteDone && lastByte) begin
      sdioOe_ff <= 1'b0;
      sdoOe_ff <= 1'b0;
    end
  end

  assign link.sdioDevOut = outBit_ff;
  assign link.sdioDevOe = sdioOe_ff;
  assign link.sdoOut = outBit_ff;
  assign link.sdoOe = sdoOe_ff;

  // register map; port config acts at once, the rest waits for update
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      portCfg_ff <= RST_PORT_CFG;
      idxShadow_ff <= RST_DEV_INDEX;
      idxActive_ff <= RST_DEV_INDEX;
      clkShadow_ff <= RST_CLOCK_SETTINGS;
      clkActive_ff <= RST_CLOCK_SETTINGS;
    end else if (wrStrobe && addr_ff[12:8] == 5'h00) begin
      case (addr_ff[7:0])
        ADDR_PORT_CFG: begin
          if (nxt_rx[CFG_SOFT_RESET_BIT]) begin
            portCfg_ff <= RST_PORT_CFG;
            idxShadow_ff <= RST_DEV_INDEX;
            idxActive_ff <= RST_DEV_INDEX;
            clkShadow_ff <= RST_CLOCK_SETTINGS;
            clkActive_ff <= RST_CLOCK_SETTINGS;
          end else begin
            portCfg_ff <= nxt_rx;
          end
        end
        ADDR_DEV_INDEX: idxShadow_ff <= nxt_rx[3:0];
        ADDR_CLOCK_SETTINGS: clkShadow_ff <= nxt_rx;
        ADDR_REGISTER_UPDATE: begin
          if (nxt_rx[UPDATE_BIT]) begin
            idxActive_ff <= idxShadow_ff;
            clkActive_ff <= clkShadow_ff;
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign dcsEnable = clkActive_ff[DCS_BIT];
  assign deviceIndex = idxActive_ff;

  // select parked high long enough hands the data pin over
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      csHighCnt_ff <= 7'h00;
      secondary_ff <= 1'b0;
    end else if (!csHigh) begin
      csHighCnt_ff <= 7'h00;
      secondary_ff <= 1'b0;
    end else if (csHighCnt_ff == 7'(SECONDARY_CYC - 1)) begin
      secondary_ff <= 1'b1;
    end else begin
      csHighCnt_ff <= csHighCnt_ff + 7'h01;
    end
  end

  assign secondaryMode = secondary_ff;
endmodule

// ### logic/acsp_host.sv
// controller end: runs one serial frame per start command
module acsp_host (
  input wire logic sys_clk,
  input wire logic arst_n,
  acsp_if.host link,
  input wire logic [3:0] cmdAddr,
  input wire logic [31:0] cmdWrData,
  input wire logic cmdWrite,
  input wire logic cmdRead,
  output logic [31:0] cmdRdData
);
  import acsp_pkg::*;

  acsp_host_state_t st_ff;
  logic [15:0] instr_ff;
  logic [23:0] txData_ff;
  logic [2:0] ctrl_ff;
  logic [23:0] rxSh_ff;
  logic [23:0] rxData_ff;
  logic [39:0] txSh_ff;
  logic [5:0] cnt_ff;
  logic [5:0] bitIdx_ff;
  logic sclk_ff;
  logic csN_ff;
  logic sdOut_ff;
  logic sdOe_ff;
  logic [1:0] sdioSync_ff;
  logic [1:0] sdoSync_ff;
  logic [31:0] cmdRdData_ff;
  logic isRead;
  logic lsb;
  logic startLsb;
  logic [1:0] lenCode;
  logic [5:0] totalBits;
  logic startReq;
  logic readBit;
  logic [39:0] loadVec;

  function automatic logic [7:0] rev8(input logic [7:0] b, input logic en);
    rev8 = b;
    if (en) begin
      for (int i = 0; i < 8; i++) begin
        rev8[i] = b[7 - i];
      end
    end
  endfunction

  assign isRead = instr_ff[INSTR_RW_BIT];
  assign lenCode = instr_ff[14:13];
  assign lsb = ctrl_ff[CTRL_LSB_BIT - 1];
  // stored order lags the start write by a cycle, so load from the command
  assign startLsb = cmdWrData[CTRL_LSB_BIT];
  // a stream is cut after three bytes by raising select
  assign totalBits = (lenCode == LEN_STREAM) ? 6'h28 : 6'(INSTR_BITS + 8 * (lenCode + 1));
  assign startReq = cmdWrite && cmdAddr == HOST_ADDR_CTRL && cmdWrData[CTRL_START_BIT]
    && st_ff == H_IDLE;
  assign loadVec = {rev8(instr_ff[7:0], startLsb), rev8(instr_ff[15:8], startLsb),
    rev8(txData_ff[23:16], startLsb), rev8(txData_ff[15:8], startLsb),
    rev8(txData_ff[7:0], startLsb)};
  assign readBit = ctrl_ff[CTRL_SDO_BIT - 1] ? sdoSync_ff[1] : sdioSync_ff[1];

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sdioSync_ff <= 2'h0;
      sdoSync_ff <= 2'h0;
    end else begin
      sdioSync_ff <= {sdioSync_ff[0], link.sdioLine};
      sdoSync_ff <= {sdoSync_ff[0], link.sdoLine};
    end
  end

  // frame engine; select is never tied low, so alignment always recovers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= H_IDLE;
      cnt_ff <= 6'h00;
      bitIdx_ff <= 6'h00;
      sclk_ff <= 1'b0;
      csN_ff <= 1'b1;
      sdOut_ff <= 1'b0;
      sdOe_ff <= 1'b0;
      txSh_ff <= 40'h00_0000_0000;
    end else begin
      unique case (st_ff)
        H_IDLE: begin
          if (startReq) begin
            // lsb-first reverses whole instruction: swap bytes too
            txSh_ff <= startLsb ? loadVec : {instr_ff, txData_ff};
            sdOut_ff <= startLsb ? loadVec[39] : instr_ff[15];
            csN_ff <= 1'b0;
            sdOe_ff <= 1'b1;
            bitIdx_ff <= 6'h00;
            cnt_ff <= 6'(SCLK_HALF_CYC - 1);
            st_ff <= H_LOW;
          end
        end
        H_LOW: begin
          if (cnt_ff == 6'h00) begin
            sclk_ff <= 1'b1;
            cnt_ff <= 6'(SCLK_HALF_CYC - 1);
            st_ff <= H_HIGH;
          end else begin
            cnt_ff <= cnt_ff - 6'h01;
          end
        end
        H_HIGH: begin
          if (cnt_ff == 6'h00) begin
            sclk_ff <= 1'b0;
            bitIdx_ff <= bitIdx_ff + 6'h01;
            txSh_ff <= {txSh_ff[38:0], 1'b0};
            cnt_ff <= 6'(SCLK_HALF_CYC - 1);
            if (bitIdx_ff == totalBits - 6'h01) begin
              sdOe_ff <= 1'b0;
              st_ff <= H_END;
            end else if (ctrl_ff[CTRL_STALL_BIT - 1] && bitIdx_ff[2:0] == 3'h7
                && lenCode != LEN_STREAM) begin
              csN_ff <= 1'b1;
              cnt_ff <= 6'(STALL_CYC - 1);
              st_ff <= H_STALL;
            end else begin
              sdOut_ff <= txSh_ff[38];
              sdOe_ff <= !(isRead && bitIdx_ff >= 6'h0F);
              st_ff <= H_LOW;
            end
          end else begin
            cnt_ff <= cnt_ff - 6'h01;
          end
        end
        H_STALL: begin
          if (cnt_ff == 6'h00) begin
            csN_ff <= 1'b0;
            sdOut_ff <= txSh_ff[39];
            sdOe_ff <= !(isRead && bitIdx_ff >= 6'h10);
            cnt_ff <= 6'(SCLK_HALF_CYC - 1);
            st_ff <= H_LOW;
          end else begin
            cnt_ff <= cnt_ff - 6'h01;
          end
        end
        H_END: begin
          if (cnt_ff == 6'h00) begin
            csN_ff <= 1'b1;
            st_ff <= H_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 6'h01;
          end
        end
        default: st_ff <= H_IDLE;
      endcase
    end
  end

  assign link.sclk = sclk_ff;
  assign link.csN = csN_ff;
  assign link.sdioHostOut = sdOut_ff;
  assign link.sdioHostOe = sdOe_ff;

  // read bits sampled just before each rising edge
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxSh_ff <= 24'h00_0000;
      rxData_ff <= 24'h00_0000;
    end else if (startReq) begin
      rxSh_ff <= 24'h00_0000;
    end else if (st_ff == H_LOW && cnt_ff == 6'h00 && isRead && bitIdx_ff >= 6'h10) begin
      rxSh_ff <= {rxSh_ff[22:0], readBit};
    end else if (st_ff == H_END && cnt_ff == 6'h00) begin
      rxData_ff <= {rev8(rxSh_ff[23:16], lsb), rev8(rxSh_ff[15:8], lsb),
        rev8(rxSh_ff[7:0], lsb)};
    end
  end

  // command registers; setup is frozen while a frame runs
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      instr_ff <= 16'h0000;
      txData_ff <= 24'h00_0000;
      ctrl_ff <= 3'h0;
      cmdRdData_ff <= 32'h0000_0000;
    end else begin
      if (cmdWrite && st_ff == H_IDLE) begin
        case (cmdAddr)
          HOST_ADDR_INSTR: instr_ff <= cmdWrData[15:0];
          HOST_ADDR_TXDATA: txData_ff <= cmdWrData[23:0];
          HOST_ADDR_CTRL: ctrl_ff <= cmdWrData[3:1];
          default: begin
          end
        endcase
      end
      cmdRdData_ff <= 32'h0000_0000;
      if (cmdRead) begin
        case (cmdAddr)
          HOST_ADDR_INSTR: cmdRdData_ff <= {16'h0000, instr_ff};
          HOST_ADDR_TXDATA: cmdRdData_ff <= {8'h00, txData_ff};
          HOST_ADDR_CTRL: cmdRdData_ff <= {28'h000_0000, ctrl_ff, 1'b0};
          HOST_ADDR_STATUS: cmdRdData_ff <= {31'h0000_0000, st_ff != H_IDLE};
          HOST_ADDR_RXDATA: cmdRdData_ff <= {8'h00, rxData_ff};
          default: cmdRdData_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign cmdRdData = cmdRdData_ff;
endmodule

// ### dv/acsp_checker.sv
// link checks between controller end and configuration port end
module acsp_checker (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic csN,
  input wire logic sdioHostOut,
  input wire logic sdioHostOe,
  input wire logic sdioDevOe,
  input wire logic sdoOe
);
  logic devDrive;
  assign devDrive = sdioDevOe | sdoOe;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence sHighHalf;
    sclk [*8] ##1 !sclk;
  endsequence
  sequence sLowHalf;
    !sclk [*8];
  endsequence
  sequence sFrameLead;
    !sclk [*4];
  endsequence
  a_frame_lead: assert property ($fell(csN) |-> sFrameLead)
    else $error("clock rose too soon after select fell");
  a_clock_idle: assert property (csN |-> !sclk)
    else $error("clock high while deselected");
  a_idle_quiet: assert property (csN [*5] |-> !devDrive)
    else $error("device drives while deselected");
  a_no_fight: assert property (!(sdioDevOe && sdioHostOe))
    else $error("both ends drive the data line");
  a_one_out_pin: assert property (!(sdioDevOe && sdoOe))
    else $error("device drives both output pins");
  a_host_hold: assert property (sclk && sdioHostOe |-> $stable(sdioHostOut))
    else $error("host data moved while clock high");
  a_high_half: assert property ($rose(sclk) |-> sHighHalf)
    else $error("clock high phase length wrong");
  a_low_half: assert property ($fell(sclk) |-> sLowHalf)
    else $error("clock low phase too short");
  a_turn_out: assert property ($rose(devDrive) |-> !sclk && !csN && $past(sclk, 6))
    else $error("device output not started after a fall");
  a_turn_in: assert property ($fell(devDrive) |-> sclk || csN)
    else $error("device output released at wrong time");
endmodule

// ### dv/adc_serial_config_port_test.sv
// self-checking bench: controller and port ends joined, plus a bit-banged port
module adc_serial_config_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  import acsp_pkg::*;
  localparam logic [7:0] TB_ID = 8'h3C; // arbitrary value
  localparam logic [7:0] TB_GRADE = 8'h00; // arbitrary value
  logic sys_clk;
  logic arst_n;
  logic [3:0] cmdAddr;
  logic [31:0] cmdWrData;
  logic cmdWrite;
  logic cmdRead;
  logic [31:0] cmdRdData;
  logic dcsEnable;
  logic [3:0] deviceIndex;
  logic secondaryMode;
  logic dcsEnableB;
  logic [31:0] rx;
  int errors;
  int checks;
  acsp_if link();
  acsp_if linkB();
  acsp_device #(.CHIP_ID_VALUE(TB_ID), .CHIP_GRADE_VALUE(TB_GRADE)) acsp_device_inst (
    .sys_clk(sys_clk), .arst_n(arst_n), .link(link), .dcsEnable(dcsEnable),
    .deviceIndex(deviceIndex), .secondaryMode(secondaryMode));
  acsp_host acsp_host_inst (.sys_clk(sys_clk), .arst_n(arst_n), .link(link),
    .cmdAddr(cmdAddr), .cmdWrData(cmdWrData), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
    .cmdRdData(cmdRdData));
  // second port faces a rule-breaking bit-bang driver
  acsp_device acsp_device_inst_b (.sys_clk(sys_clk), .arst_n(arst_n), .link(linkB),
    .dcsEnable(dcsEnableB), .deviceIndex(), .secondaryMode());
  acsp_checker acsp_checker_inst (.sys_clk(sys_clk), .arst_n(arst_n), .sclk(link.sclk),
    .csN(link.csN), .sdioHostOut(link.sdioHostOut), .sdioHostOe(link.sdioHostOe),
    .sdioDevOe(link.sdioDevOe), .sdoOe(link.sdoOe));
  always #50 sys_clk = ~sys_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  function automatic logic [15:0] ins(input logic rd, input logic [1:0] len,
      input logic [7:0] a);
    return {rd, len, 5'h00, a};
  endfunction
  task automatic cmd_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cmdAddr <= a;
    cmdWrData <= d;
    cmdWrite <= 1'h1;
    @(posedge sys_clk);
    cmdWrite <= 1'h0;
  endtask
  task automatic cmd_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    cmdAddr <= a;
    cmdRead <= 1'h1;
    @(posedge sys_clk);
    cmdRead <= 1'h0;
    @(posedge sys_clk);
    d = cmdRdData;
  endtask
  // one whole frame through the controller, waits for it to finish
  task automatic frame(input logic [15:0] iw, input logic [23:0] tx, input logic [3:0] ctl,
      output logic [31:0] d);
    logic [31:0] st;
    int n;
    n = 0;
    st = 32'h1;
    cmd_wr(HOST_ADDR_INSTR, {16'h0000, iw});
    cmd_wr(HOST_ADDR_TXDATA, {8'h00, tx});
    cmd_wr(HOST_ADDR_CTRL, {28'h0, ctl | 4'h1});
    while (st[0] !== 1'h0 && n < 2000) begin
      cmd_rd(HOST_ADDR_STATUS, st);
      n++;
    end
    check(st, 32'h0);
    cmd_rd(HOST_ADDR_RXDATA, d);
  endtask
  task automatic wr1(input logic [7:0] a, input logic [7:0] v, input logic [3:0] ctl);
    frame(ins(1'h0, 2'h0, a), {v, 16'h0000}, ctl, rx);
  endtask
  task automatic rd1(input logic [7:0] a, input logic [3:0] ctl, input logic [7:0] exp);
    frame(ins(1'h1, 2'h0, a), 24'h0, ctl, rx);
    check(rx, {24'h0, exp});
  endtask
  // first n bits of w, MSB first, data changed while clock low
  task automatic bang(input logic [23:0] w, input int n);
    for (int i = 23; i > 23 - n; i--) begin
      linkB.sdioHostOut <= w[i];
      repeat (BENCH_HALF_CYC) @(posedge sys_clk);
      linkB.sclk <= 1'h1;
      repeat (BENCH_HALF_CYC) @(posedge sys_clk);
      linkB.sclk <= 1'h0;
    end
  endtask
  task automatic bframe(input logic [23:0] w, input int n);
    linkB.csN <= 1'h0;
    linkB.sdioHostOe <= 1'h1;
    repeat (8) @(posedge sys_clk);
    bang(w, n);
    repeat (8) @(posedge sys_clk);
    linkB.csN <= 1'h1;
    linkB.sdioHostOe <= 1'h0;
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic reset_values();
    @(posedge sys_clk);
    check(32'(dcsEnable), 32'h1);
    check(32'(deviceIndex), 32'hF);
    check(32'(secondaryMode), 32'h0);
    repeat (SECONDARY_CYC + 4) @(posedge sys_clk);
    check(32'(secondaryMode), 32'h1);
    rd1(ADDR_CLOCK_SETTINGS, 4'h0, 8'h01);
    rd1(ADDR_PORT_CFG, 4'h0, 8'h18);
    check(32'(secondaryMode), 32'h0);
  endtask
  task automatic staged_write();
    wr1(ADDR_CLOCK_SETTINGS, 8'h00, 4'h0);
    check(32'(dcsEnable), 32'h1);
    rd1(ADDR_CLOCK_SETTINGS, 4'h0, 8'h00);
    wr1(ADDR_REGISTER_UPDATE, 8'h01, 4'h0);
    check(32'(dcsEnable), 32'h0);
    // mid-run reset must bring the active clock setting back
    @(posedge sys_clk);
    arst_n <= 1'h0;
    repeat (3) @(posedge sys_clk);
    check(32'(dcsEnable), 32'h1);
    arst_n <= 1'h1;
  endtask
  // two bytes from 0x06 downward with select raised between bytes
  task automatic multi_byte_stall();
    frame(ins(1'h0, 2'h1, 8'h06), 24'hAA0300, 4'h8, rx);
    check(32'(deviceIndex), 32'hF);
    wr1(ADDR_REGISTER_UPDATE, 8'h01, 4'h0);
    check(32'(deviceIndex), 32'h3);
    frame(ins(1'h1, 2'h1, 8'h06), 24'h0, 4'h0, rx);
    check(rx, 32'h0003);
  endtask
  task automatic stream_read();
    frame(ins(1'h1, LEN_STREAM, ADDR_CHIP_GRADE), 24'h0, 4'h0, rx);
    check(rx, {8'h00, TB_GRADE, TB_ID, RST_PORT_CFG});
  endtask
  task automatic sdo_read();
    wr1(ADDR_PORT_CFG, 8'h98, 4'h0);
    rd1(ADDR_PORT_CFG, 4'h4, 8'h98);
    rd1(ADDR_PORT_CFG, 4'h0, 8'h00);
    wr1(ADDR_PORT_CFG, 8'h18, 4'h0);
  endtask
  // LSB-first steps upward: 0x04 dropped, 0x05 takes the second byte
  task automatic lsb_mode();
    wr1(ADDR_PORT_CFG, 8'h58, 4'h0);
    frame(ins(1'h0, 2'h1, 8'h04), 24'h110600, 4'h2, rx);
    wr1(ADDR_REGISTER_UPDATE, 8'h01, 4'h2);
    check(32'(deviceIndex), 32'h6);
    wr1(ADDR_PORT_CFG, 8'h78, 4'h2);
    check(32'(dcsEnable), 32'h1);
    check(32'(deviceIndex), 32'hF);
    rd1(ADDR_PORT_CFG, 4'h0, 8'h18);
  endtask
  task automatic abort_resync();
    bframe(24'hFFFFFF, 4);
    bframe({ins(1'h0, 2'h0, ADDR_CLOCK_SETTINGS), 8'h00}, 24);
    bframe({ins(1'h0, 2'h0, ADDR_REGISTER_UPDATE), 8'h01}, 24);
    check(32'(dcsEnableB), 32'h0);
  endtask
  // select held low across two frames
  task automatic two_wire();
    linkB.csN <= 1'h0;
    linkB.sdioHostOe <= 1'h1;
    repeat (8) @(posedge sys_clk);
    bang({ins(1'h0, 2'h0, ADDR_CLOCK_SETTINGS), 8'h01}, 24);
    bang({ins(1'h0, 2'h0, ADDR_REGISTER_UPDATE), 8'h01}, 24);
    repeat (8) @(posedge sys_clk);
    check(32'(dcsEnableB), 32'h1);
  endtask
  initial begin
    sys_clk = 1'h0;
    arst_n = 1'h0;
    cmdAddr = 4'h0;
    cmdWrData = 32'h0;
    cmdWrite = 1'h0;
    cmdRead = 1'h0;
    linkB.sclk = 1'h0;
    linkB.csN = 1'h1;
    linkB.sdioHostOut = 1'h0;
    linkB.sdioHostOe = 1'h0;
    errors = 0;
    checks = 0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'h1;
    reset_values();
    staged_write();
    multi_byte_stall();
    stream_read();
    sdo_read();
    lsb_mode();
    abort_resync();
    two_wire();
    end_of_test();
  end
  // about six to seven times the expected run length
  initial begin
    repeat (60000) @(posedge sys_clk);
    errors++;
    end_of_test();
  end
endmodule
